//--- core/pmicp_port.sv
/*
 * Two-wire serial slave command port: address match, sub-addressed
 * writes into holding latches, commit to the active command set on stop,
 * single-byte read-back, interrupt clear, and LED current scaling.
 * Assumes the bus pins and the supply monitor level are asynchronous;
 * status bytes come from logic on clk. Open-drain data is modelled as
 * sda_o/sda_oe; the bench resolves the wire.
 */
// Behaviour
//RULE1: low interface supply clears port and registers
//RULE2: filtered inputs, works up to 400 kHz
//RULE3: detect start, sda falls with scl high
//RULE4: detect stop, sda rises with scl high
//RULE5: stop copies held data to active set
//RULE6: bytes are eight bits, msb first, ack
//RULE7: write acks address, sub-address and data
//RULE8: read acks address, sends one byte only
//RULE9: hold sda low across ack clock high
//RULE10: master acknowledges read data byte
//RULE11: one fixed 7-bit address per variant
//RULE12: address lsb selects write or read
//RULE13: acknowledge only on own address
//RULE14: write is address, sub-address, data
//RULE15: acked data byte enters holding latch
//RULE16: master repeats sequence per register
//RULE17: eleven writable registers by sub-address
//RULE18: 8-bit code sets proportional LED current
//RULE19: double-scale bit doubles LED step
//RULE20: clear-interrupt sub-address acts on stop
//RULE21: repeated start read returns selected register
//RULE22: sub-address upper nibble must be zero
//RULE23: ignore writes to unused or read-only
//RULE24: start or stop mid-byte abandons byte
`timescale 1ns/100ps
module pmicp_port #(
    parameter bit VARIANT_B = 1'b0
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // interface logic supply monitor, high when above lockout
    input  wire logic                  supply_ok,
    // serial bus
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    // status bytes for read-back
    input  wire logic [7:0]            status_rt,
    input  wire logic [7:0]            status_latched,
    // command set and effects
    output pmicp_pkg::pmicp_regs_t     cmd_regs,
    output logic [8:0]                 led_sink_steps,
    output logic                       int_clear
);
    localparam logic [6:0] OWN_ADDR = VARIANT_B ? pmicp_pkg::SLAVE_ADDR_B
                                                : pmicp_pkg::SLAVE_ADDR_A;

    pmicp_pkg::pmicp_state_t   state_q;
    pmicp_pkg::pmicp_bus_evt_t evt;
    pmicp_pkg::pmicp_regs_t    hold_q;
    logic [1:0]                supply_sync_q;
    logic                      clear;
    logic [7:0]                shreg_q;
    logic [7:0]                tx_q;
    logic [2:0]                bit_cnt_q;
    logic [2:0]                tx_cnt_q;
    logic                      got8_q;
    logic [7:0]                sub_q;
    logic                      clr_armed_q;
    logic                      ack_now;
    logic                      sub_ok;

    // supply monitor comes from outside the clock domain
    always_ff @(posedge clk) begin
        supply_sync_q <= {supply_sync_q[0], supply_ok};
    end

    assign clear = !rst_n || !supply_sync_q[1]; // RULE1

    pmicp_line_filter #(
        .FILT_CYC (pmicp_pkg::GLITCH_CYC)
    ) u_filter (
        .clk   (clk),
        .rst_n (rst_n),
        .clear (clear),
        .scl_i (scl_i),
        .sda_i (sda_i),
        .evt   (evt)
    ); // RULE2

    function automatic logic sub_writable(input logic [7:0] sub);
        return (sub[7:4] == pmicp_pkg::SUB_HI_ZERO) &&
               (sub[3:0] >= pmicp_pkg::SUB_FIRST) &&
               (32'(sub[3:0]) <= pmicp_pkg::NUM_REGS);
    endfunction : sub_writable

    assign sub_ok = sub_writable(sub_q); // RULE22 RULE23

    // ack decision on the falling edge after the eighth bit
    always_comb begin
        ack_now = 1'b0;
        if (state_q == pmicp_pkg::ST_ADDR) begin
            ack_now = (shreg_q[7:1] == OWN_ADDR); // RULE11 RULE13
        end else if (state_q == pmicp_pkg::ST_SUB || state_q == pmicp_pkg::ST_DATA) begin
            ack_now = 1'b1; // RULE7
        end
    end

    // byte shifter, msb first
    always_ff @(posedge clk) begin
        if (clear || evt.start || evt.stop) begin
            bit_cnt_q <= 3'h0; // RULE24
            got8_q    <= 1'b0;
        end else if (evt.scl_rise && (state_q == pmicp_pkg::ST_ADDR ||
                     state_q == pmicp_pkg::ST_SUB || state_q == pmicp_pkg::ST_DATA)) begin
            shreg_q   <= {shreg_q[6:0], evt.sda}; // RULE6
            bit_cnt_q <= bit_cnt_q + 3'h1;
            got8_q    <= (bit_cnt_q == 3'h7);
        end else if (evt.scl_fall && got8_q) begin
            got8_q <= 1'b0;
        end
    end

    // transaction sequencer and data line drive
    always_ff @(posedge clk) begin
        if (clear || evt.stop) begin
            state_q <= pmicp_pkg::ST_IDLE; // RULE1 RULE4
            sda_oe  <= 1'b0;
        end else if (evt.start) begin
            state_q <= pmicp_pkg::ST_ADDR; // RULE3 RULE21
            sda_oe  <= 1'b0;
        end else if (evt.scl_fall) begin
            case (state_q)
                pmicp_pkg::ST_ADDR, pmicp_pkg::ST_SUB, pmicp_pkg::ST_DATA: begin
                    if (got8_q) begin
                        sda_oe  <= ack_now; // RULE9
                        state_q <= !ack_now ? pmicp_pkg::ST_IDLE :
                                   state_q == pmicp_pkg::ST_ADDR ? pmicp_pkg::ST_ADDR_ACK :
                                   state_q == pmicp_pkg::ST_SUB  ? pmicp_pkg::ST_SUB_ACK :
                                                                   pmicp_pkg::ST_DATA_ACK;
                    end
                end
                pmicp_pkg::ST_ADDR_ACK: begin
                    if (shreg_q[0]) begin
                        sda_oe  <= ~tx_q[7]; // RULE8
                        state_q <= pmicp_pkg::ST_TX;
                    end else begin
                        sda_oe  <= 1'b0;
                        state_q <= pmicp_pkg::ST_SUB; // RULE12 RULE14
                    end
                end
                pmicp_pkg::ST_SUB_ACK: begin
                    sda_oe  <= 1'b0;
                    state_q <= pmicp_pkg::ST_DATA;
                end
                pmicp_pkg::ST_DATA_ACK: begin
                    sda_oe  <= 1'b0;
                    state_q <= pmicp_pkg::ST_SUB; // RULE16
                end
                pmicp_pkg::ST_TX: begin
                    if (tx_cnt_q == 3'h7) begin
                        sda_oe  <= 1'b0; // RULE8
                        state_q <= pmicp_pkg::ST_TX_ACK;
                    end else begin
                        sda_oe <= ~tx_q[6];
                    end
                end
                pmicp_pkg::ST_TX_ACK: begin
                    state_q <= pmicp_pkg::ST_IDLE; // RULE8 RULE10
                end
                default: begin
                    state_q <= pmicp_pkg::ST_IDLE;
                    sda_oe  <= 1'b0;
                end
            endcase
        end
    end

    // own transmit count: the receive counter does not move while sending
    always_ff @(posedge clk) begin
        if (clear || evt.start || evt.stop) begin
            tx_cnt_q <= 3'h0;
        end else if (evt.scl_fall && state_q == pmicp_pkg::ST_TX) begin
            tx_cnt_q <= tx_cnt_q + 3'h1;
        end
    end

    // read-back byte, loaded at the end of every address byte, matched or not
    always_ff @(posedge clk) begin
        if (clear) begin
            tx_q <= 8'h00;
        end else if (evt.scl_fall && state_q == pmicp_pkg::ST_ADDR && got8_q) begin
            if (sub_ok) begin
                tx_q <= hold_q[sub_q[3:0]]; // RULE21
            end else if (sub_q == {pmicp_pkg::SUB_HI_ZERO, pmicp_pkg::SUB_STAT_RT}) begin
                tx_q <= status_rt;
            end else if (sub_q == {pmicp_pkg::SUB_HI_ZERO, pmicp_pkg::SUB_STAT_LT}) begin
                tx_q <= status_latched;
            end else begin
                tx_q <= 8'h00;
            end
        end else if (evt.scl_fall && state_q == pmicp_pkg::ST_TX) begin
            tx_q <= {tx_q[6:0], 1'b0}; // RULE6
        end
    end

    // sub-address pointer survives a repeated start for read-back
    always_ff @(posedge clk) begin
        if (clear) begin
            sub_q <= 8'h00;
        end else if (evt.scl_fall && state_q == pmicp_pkg::ST_SUB && got8_q) begin
            sub_q <= shreg_q;
        end else if (evt.stop && got8_q == 1'b0 && state_q == pmicp_pkg::ST_SUB
                     && bit_cnt_q != 3'h0) begin
            sub_q <= 8'h00; // RULE24
        end
    end

    // holding latches take each acked data byte with a writable sub-address
    always_ff @(posedge clk) begin
        if (clear) begin
            hold_q <= pmicp_pkg::pmicp_defaults(); // RULE1
        end else if (evt.scl_fall && state_q == pmicp_pkg::ST_DATA && got8_q && sub_ok) begin
            hold_q[sub_q[3:0]] <= shreg_q; // RULE15 RULE17 RULE23
        end
    end

    // nothing reaches the command set before the stop
    always_ff @(posedge clk) begin
        if (clear) begin
            cmd_regs <= pmicp_pkg::pmicp_defaults(); // RULE1
        end else if (evt.stop) begin
            cmd_regs <= hold_q; // RULE5
        end
    end

    // clear interrupt needs no data byte; it fires on the stop
    always_ff @(posedge clk) begin
        if (clear) begin
            clr_armed_q <= 1'b0;
            int_clear   <= 1'b0;
        end else begin
            int_clear <= evt.stop && clr_armed_q; // RULE20
            if (evt.stop || evt.start) begin
                clr_armed_q <= 1'b0;
            end else if (evt.scl_fall && state_q == pmicp_pkg::ST_SUB && got8_q) begin
                clr_armed_q <= (shreg_q == pmicp_pkg::SUB_INT_CLEAR); // RULE20
            end
        end
    end

    // sink current in code steps, doubled when double-scale is set
    always_ff @(posedge clk) begin
        if (clear) begin
            led_sink_steps <= 9'h000;
        end else if (cmd_regs[pmicp_pkg::SUB_LED_SETUP][pmicp_pkg::DOUBLE_BIT]) begin
            led_sink_steps <= {cmd_regs[pmicp_pkg::SUB_LED_CODE], 1'b0}; // RULE19
        end else begin
            led_sink_steps <= {1'b0, cmd_regs[pmicp_pkg::SUB_LED_CODE]}; // RULE18
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge clk) begin
        sda_o <= 1'b0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_LOCKOUT: assert property (!supply_sync_q[1] |=> state_q == pmicp_pkg::ST_IDLE
        && !sda_oe && cmd_regs == pmicp_pkg::pmicp_defaults()) // RULE1
        else $error("lockout did not clear the port");
    AST_START: assert property (evt.start && !clear |=> state_q == pmicp_pkg::ST_ADDR
        && bit_cnt_q == 3'h0) // RULE3
        else $error("start not detected");
    AST_STOP_IDLE: assert property (evt.stop |=> state_q == pmicp_pkg::ST_IDLE && !sda_oe) // RULE4
        else $error("stop did not free the bus");
    AST_COMMIT: assert property (evt.stop && !clear |=> cmd_regs == $past(hold_q)) // RULE5
        else $error("stop did not commit held data");
    AST_NO_EARLY: assert property (!evt.stop && !clear |=> $stable(cmd_regs)) // RULE5
        else $error("command set changed without stop");
    AST_ACK_HOLD: assert property ((state_q == pmicp_pkg::ST_ADDR_ACK ||
        state_q == pmicp_pkg::ST_SUB_ACK || state_q == pmicp_pkg::ST_DATA_ACK) && sda_oe
        && !evt.scl_fall && !evt.start && !evt.stop && !clear |=> sda_oe) // RULE9
        else $error("ack released early");
    AST_NO_ACK_FOREIGN: assert property (evt.scl_fall && got8_q && state_q == pmicp_pkg::ST_ADDR
        && shreg_q[7:1] != OWN_ADDR && !evt.start && !evt.stop && !clear
        |=> !sda_oe && state_q == pmicp_pkg::ST_IDLE) // RULE13
        else $error("foreign address acknowledged");
    AST_IGNORE_RO: assert property (evt.scl_fall && got8_q && state_q == pmicp_pkg::ST_DATA
        && !sub_ok && !clear |=> $stable(hold_q)) // RULE23
        else $error("write to unused sub-address landed");
    AST_DOUBLE: assert property (cmd_regs[pmicp_pkg::SUB_LED_SETUP][pmicp_pkg::DOUBLE_BIT]
        && !clear |=> led_sink_steps == {$past(cmd_regs[pmicp_pkg::SUB_LED_CODE]), 1'b0}) // RULE19
        else $error("double-scale not applied");
    AST_TX_RELEASE: assert property (state_q == pmicp_pkg::ST_TX_ACK |-> !sda_oe) // RULE8
        else $error("data held during master ack");

    COV_COMMIT: cover property (evt.stop && hold_q != cmd_regs);
    COV_READ: cover property (state_q == pmicp_pkg::ST_TX ##[1:1000] state_q == pmicp_pkg::ST_TX_ACK);
    COV_INT_CLEAR: cover property (int_clear);

endmodule : pmicp_port

//--- include/pmicp_pkg.sv
/*
 * Constants, register layout and carrier types for the power-management
 * two-wire command port.
 * Assumes one 40 MHz clock and a synchronous active-low reset.
 */
package pmicp_pkg;

    // clock and glitch filter timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int GLITCH_NS     = 50;
    localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // slave addresses of the two variants
    localparam logic [6:0] SLAVE_ADDR_A = 7'h09;
    localparam logic [6:0] SLAVE_ADDR_B = 7'h34;

    // sub-address map
    localparam int         NUM_REGS      = 11;
    localparam logic [3:0] SUB_FIRST     = 4'h1;
    localparam logic [3:0] SUB_LED_SETUP = 4'h7;
    localparam logic [3:0] SUB_LED_CODE  = 4'h8;
    localparam logic [3:0] SUB_STAT_RT   = 4'hC;
    localparam logic [3:0] SUB_STAT_LT   = 4'hD;
    localparam logic [7:0] SUB_INT_CLEAR = 8'h0F;
    localparam logic [3:0] SUB_HI_ZERO   = 4'h0;
    localparam int         DOUBLE_BIT    = 3;

    // reset values
    localparam logic [7:0] RST_BUCK      = 8'h6F;
    localparam logic [7:0] RST_CONV      = 8'h0F;
    localparam logic [7:0] RST_LED_SETUP = 8'h0F;
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_MASK_ALL  = 8'hFF;
    localparam logic [3:0] SUB_LAST_BUCK = 4'h4;
    localparam logic [3:0] SUB_LAST_CONV = 4'h6;
    localparam logic [3:0] SUB_RST_MASK  = 4'hA;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_ADDR     = 4'b0001,
        ST_ADDR_ACK = 4'b0010,
        ST_SUB      = 4'b0011,
        ST_SUB_ACK  = 4'b0100,
        ST_DATA     = 4'b0101,
        ST_DATA_ACK = 4'b0110,
        ST_TX       = 4'b0111,
        ST_TX_ACK   = 4'b1000
    } pmicp_state_t;

    // filtered bus levels and events
    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } pmicp_bus_evt_t;

    typedef logic [NUM_REGS:1][7:0] pmicp_regs_t;

    function automatic logic [7:0] pmicp_default(input logic [3:0] idx);
        if (idx <= SUB_LAST_BUCK) begin
            return RST_BUCK;
        end else if (idx <= SUB_LAST_CONV) begin
            return RST_CONV;
        end else if (idx == SUB_LED_SETUP) begin
            return RST_LED_SETUP;
        end else if (idx == SUB_RST_MASK) begin
            return RST_MASK_ALL;
        end else begin
            return RST_ZERO;
        end
    endfunction : pmicp_default

    function automatic pmicp_regs_t pmicp_defaults();
        pmicp_regs_t r;
        for (int i = 1; i <= NUM_REGS; i++) begin
            r[i] = pmicp_default(4'(i));
        end
        return r;
    endfunction : pmicp_defaults

endpackage : pmicp_pkg

//--- core/pmicp_line_filter.sv
/*
 * Synchroniser and glitch filter for the serial clock and data lines,
 * plus detection of clock edges and start/stop conditions.
 * Assumes the pins are asynchronous to clk; outputs are registered.
 */
`timescale 1ns/100ps
module pmicp_line_filter #(
    parameter int FILT_CYC = pmicp_pkg::GLITCH_CYC
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     clear,
    // raw lines
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    // filtered result
    output pmicp_pkg::pmicp_bus_evt_t     evt
);
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic [1:0] clean_q;
    logic [1:0] cnt_q [2];

    always_ff @(posedge clk) begin
        meta_q <= {scl_i, sda_i};
        sync_q <= meta_q;
    end

    // a level must hold for FILT_CYC cycles before it is believed
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (!rst_n || clear) begin
                clean_q[i] <= 1'b1;
                cnt_q[i]   <= 2'h0;
            end else if (sync_q[i] == clean_q[i]) begin
                cnt_q[i] <= 2'h0;
            end else if (32'(cnt_q[i]) >= FILT_CYC - 1) begin
                clean_q[i] <= sync_q[i];
                cnt_q[i]   <= 2'h0;
            end else begin
                cnt_q[i] <= cnt_q[i] + 2'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            evt <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
        end else begin
            evt.scl      <= clean_q[1];
            evt.sda      <= clean_q[0];
            evt.scl_rise <= clean_q[1] & ~evt.scl;
            evt.scl_fall <= ~clean_q[1] & evt.scl;
            evt.start    <= clean_q[1] & evt.scl & evt.sda & ~clean_q[0];
            evt.stop     <= clean_q[1] & evt.scl & ~evt.sda & clean_q[0];
        end
    end

endmodule : pmicp_line_filter

//--- tb/pmicp_tb_master.sv
/*
 * Two-wire bus master model: start, stop, byte write and byte read.
 * Assumes the bench resolves sda as wired-and with a pull-up.
 */
`timescale 1ns/100ps
module pmicp_tb_master (
    // pacing clock
    input  wire logic clk,
    // bus lines
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    initial begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end

    task automatic step(input int n, input logic c, input logic d);
        repeat (n) @(posedge clk);
        scl     <= c;
        sda_rel <= d;
    endtask : step

    // long low phase: the slave lets go of sda some clocks after scl falls
    task automatic clk_bit(input logic b, input bit g, output logic s);
        if (g) begin
            step(3, 1'b1, sda_rel);
            step(1, 1'b0, sda_rel);
            step(4, 1'b0, b);
        end else begin
            step(8, 1'b0, b);
        end
        step(4, 1'b1, b);
        repeat (6) @(posedge clk);
        s = sda;
        step(2, 1'b0, b);
    endtask : clk_bit

    task automatic start_c();
        step(8, scl, 1'b1);
        step(4, 1'b1, 1'b1);
        step(8, 1'b1, 1'b0);
        step(8, 1'b0, 1'b0);
    endtask : start_c

    task automatic stop_c();
        step(8, 1'b0, 1'b0);
        step(4, 1'b1, 1'b0);
        step(8, 1'b1, 1'b1);
        repeat (8) @(posedge clk);
    endtask : stop_c

    // nb below 8 cuts the byte short with no ack clock
    task automatic wbyte(input logic [7:0] v, input bit g, input int nb, output logic ack);
        logic s;
        ack = 1'b1;
        for (int i = 7; i > 7 - nb; i--) begin
            clk_bit(v[i], g && i == 7, s);
        end
        if (nb == 8) begin
            clk_bit(1'b1, 1'b0, ack);
        end
    endtask : wbyte

    task automatic rbyte(input logic mack, output logic [7:0] v, output logic s9);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, 1'b0, s);
            v[i] = s;
        end
        clk_bit(mack, 1'b0, s9);
    endtask : rbyte
endmodule : pmicp_tb_master

//--- tb/tb_top.sv
/*
 * Self-checking bench for the two-wire command port: a model of holding
 * latches and active set is compared after every transfer.
 * Assumes the package, the port and the master model are compiled first.
 */
`timescale 1ns/100ps
module tb_top;
    logic                   clk            = 1'b0;
    logic                   rst_n          = 1'b0;
    logic                   supply_ok      = 1'b1;
    logic [7:0]             status_rt      = 8'h00;
    logic [7:0]             status_latched = 8'h00;
    logic                   scl;
    logic                   m_rel;
    wire                    sda_w;
    logic                   sda_o;
    logic                   sda_oe;
    pmicp_pkg::pmicp_regs_t cmd_regs;
    logic [8:0]             led_sink_steps;
    logic                   int_clear;
    logic [15:0]            lfsr_q = 16'hD5A1;
    logic                   ack;
    logic                   s9;
    logic [7:0]             rv;
    logic [7:0]             x;
    int                     error_cnt = 0;
    int                     checks_done = 0;
    int                     cycles = 0;
    int                     clr_cnt = 0;
    int                     mreg [1:11];
    int                     hold [1:11];

    always #12.5 clk = ~clk;

    // open drain with pull-up: low while either side pulls
    assign sda_w = m_rel & ~(sda_oe === 1'b1);

    pmicp_tb_master m (.clk(clk), .scl(scl), .sda_rel(m_rel), .sda(sda_w));

    pmicp_port #(.VARIANT_B(1'b0)) uut (
        .clk            (clk),
        .rst_n          (rst_n),
        .supply_ok      (supply_ok),
        .scl_i          (scl),
        .sda_i          (sda_w),
        .sda_o          (sda_o),
        .sda_oe         (sda_oe),
        .status_rt      (status_rt),
        .status_latched (status_latched),
        .cmd_regs       (cmd_regs),
        .led_sink_steps (led_sink_steps),
        .int_clear      (int_clear)
    );

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        cycles++;
        if (int_clear === 1'b1) begin
            clr_cnt++;
        end
        if (cycles == 30000) begin
            error_cnt++;
            final_report();
        end
    end

    function automatic logic [7:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q[7:0];
    endfunction : rnd

    task automatic cmp_val(input string nm, input logic [8:0] e, input logic [8:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_val

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_bit

    task automatic model_reset();
        for (int i = 1; i <= 11; i++) begin
            mreg[i] = i <= 4 ? 8'h6F : i <= 7 ? 8'h0F : i == 10 ? 8'hFF : 8'h00;
            hold[i] = mreg[i];
        end
    endtask : model_reset

    task automatic check_set();
        int st;
        repeat (8) @(posedge clk);
        for (int i = 1; i <= 11; i++) begin
            cmp_val("cmd_regs", 9'(mreg[i]), {1'b0, cmd_regs[i]});
        end
        st = mreg[7][3] ? mreg[8] * 2 : mreg[8];
        cmp_val("led_sink_steps", 9'(st), led_sink_steps);
        cmp_bit("sda_o", 1'b0, sda_o);
    endtask : check_set

    task automatic commit();
        m.stop_c();
        mreg = hold;
        check_set();
    endtask : commit

    task automatic send(input logic [7:0] v, input bit g, input logic e);
        m.wbyte(v, g, 8, ack);
        cmp_bit("ack", e, ack);
    endtask : send

    task automatic wr(input logic [7:0] sub, input logic [7:0] d);
        send(sub, 1'b0, 1'b0);
        send(d, 1'b0, 1'b0);
        if (sub >= 8'h01 && sub <= 8'h0B) begin
            hold[sub] = d;
        end
    endtask : wr

    task automatic rd(input logic [7:0] sub, output logic [7:0] v);
        m.start_c();
        send(8'h12, 1'b0, 1'b0);
        send(sub, 1'b0, 1'b0);
        m.start_c();
        send(8'h13, 1'b0, 1'b0);
        m.rbyte(1'b1, v, s9);
        cmp_bit("sda released", 1'b1, s9);
        commit();
    endtask : rd

    initial begin
        model_reset();
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check_set();
        // written data must not reach the active set before stop
        x = rnd();
        m.start_c();
        send(8'h12, 1'b0, 1'b0);
        wr(8'h08, x);
        check_set();
        rd(8'h08, rv);
        cmp_val("readback", {1'b0, x}, {1'b0, rv});
        // every register in one transfer, glitch on the address byte
        m.start_c();
        send(8'h12, 1'b1, 1'b0);
        for (int i = 1; i <= 11; i++) begin
            wr(8'(i), i == 7 ? rnd() | 8'h08 : rnd());
        end
        wr(8'h1B, rnd());
        wr(8'h0C, rnd());
        commit();
        status_rt      <= rnd();
        status_latched <= rnd();
        rd(8'h0C, rv);
        cmp_val("status_rt", {1'b0, status_rt}, {1'b0, rv});
        rd(8'h0D, rv);
        cmp_val("status_latched", {1'b0, status_latched}, {1'b0, rv});
        rd(8'h0E, rv);
        cmp_val("unused read", 9'h000, {1'b0, rv});
        // other variant address: no ack, port stays out
        m.start_c();
        send(8'h68, 1'b0, 1'b1);
        send(8'h08, 1'b0, 1'b1);
        commit();
        // clear acts at stop, null sub-address clears nothing
        clr_cnt = 0;
        m.start_c();
        send(8'h12, 1'b0, 1'b0);
        send(8'h0F, 1'b0, 1'b0);
        commit();
        cmp_val("int_clear pulses", 9'h001, 9'(clr_cnt));
        m.start_c();
        send(8'h12, 1'b0, 1'b0);
        send(8'h00, 1'b0, 1'b0);
        commit();
        cmp_val("int_clear pulses", 9'h001, 9'(clr_cnt));
        // stop in mid data byte drops the byte
        m.start_c();
        send(8'h12, 1'b0, 1'b0);
        send(8'h08, 1'b0, 1'b0);
        m.wbyte(~8'(mreg[8]), 1'b0, 4, ack);
        commit();
        // supply lockout returns defaults
        supply_ok <= 1'b0;
        repeat (6) @(posedge clk);
        supply_ok <= 1'b1;
        model_reset();
        check_set();
        final_report();
    end
endmodule : tb_top
